/* hdl/itc_top.sv */
// Purpose: Command decode for a three-channel interval timer and port B
// Assumes: io_wr and io_rd are one-cycle strobes; counting cores are external
// Notes: Read data appears in io_rdata_ff one cycle after io_rd
`timescale 1ns/1ps
module itc_top (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata_ff,
    input wire logic [2:0][15:0] count_live,
    input wire logic [2:0] timer_out,
    input wire logic [2:0] null_count,
    input wire logic refresh_tick,
    output itc_pkg::itc_cfg_t [2:0] chan_cfg,
    output logic [2:0] chan_reprogram,
    output logic [2:0] timer_gate,
    output logic speaker_drive
);
    import itc_pkg::*;

    itc_cmd_t cmd;
    logic cmd_wr;
    logic is_rb;
    logic is_latch;
    logic [2:0] prog;
    logic [2:0] latch_cnt;
    logic [2:0] latch_stat;
    logic [2:0] chan_rd;
    logic [2:0][7:0] chan_byte;
    logic [2:0] picks;
    logic [7:0] pb_byte;
    logic pb_wr;
    logic pb_rd;
    logic chan_addr;
    logic [1:0] idx;
    logic [1:0] fixed_gates_ff;
    logic gate2_ff;
    logic rb_fresh_ff;

    assign cmd = itc_cmd_t'(io_wdata);
    assign cmd_wr = io_wr && io_addr == ADDR_CMD;
    assign is_rb = cmd_wr && cmd.sel == SEL_READBACK;
    assign is_latch = cmd_wr && !is_rb && cmd.acc == ACC_LATCH;
    assign picks = cmd.mode;
    assign pb_wr = io_wr && io_addr == ADDR_PORTB;
    assign pb_rd = io_rd && io_addr == ADDR_PORTB;
    assign chan_addr = io_addr >= ADDR_PICK_TIMER_ZERO && io_addr <= ADDR_PICK_TIMER_TWO;
    assign idx = io_addr[1:0];

    // Low-nibble and bit-0 contents of latch/read-back writes are not checked
    generate
        for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
            assign prog[c] = cmd_wr && !is_rb && cmd.acc != ACC_LATCH
                && cmd.sel == 2'(c);
            assign latch_cnt[c] = (is_latch && cmd.sel == 2'(c))
                || (is_rb && !cmd.acc[1] && picks[c]);
            assign latch_stat[c] = is_rb && !cmd.acc[0] && picks[c];
            assign chan_rd[c] = io_rd && chan_addr && idx == 2'(c);
            itc_chan u_chan (
                .sys_clk(sys_clk),
                .reset_n(reset_n),
                .prog(prog[c]),
                .cmd(cmd),
                .latch_cnt(latch_cnt[c]),
                .latch_stat(latch_stat[c]),
                .rd(chan_rd[c]),
                .live_count(count_live[c]),
                .out_level(timer_out[c]),
                .null_count(null_count[c]),
                .rd_byte(chan_byte[c]),
                .cfg_ff(chan_cfg[c]),
                .reprogram_ff(chan_reprogram[c])
            );
        end
    endgenerate

    itc_portb u_portb (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .wr(pb_wr),
        .wdata(io_wdata),
        .t2_out(timer_out[2]),
        .refresh_tick(refresh_tick),
        .rd_byte(pb_byte),
        .gate_ff(gate2_ff),
        .speaker_ff(speaker_drive)
    );

    // Channels 0 and 1 have no gate control
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            fixed_gates_ff <= FIXED_GATES;
        end else begin
            fixed_gates_ff <= FIXED_GATES;
        end
    end

    assign timer_gate = {gate2_ff, fixed_gates_ff};

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            io_rdata_ff <= RDATA_RESET;
        end else if (io_rd) begin
            if (pb_rd) begin
                io_rdata_ff <= pb_byte;
            end else if (chan_addr) begin
                io_rdata_ff <= chan_byte[idx];
            end else begin
                io_rdata_ff <= RDATA_RESET;
            end
        end
    end

    // Checks
    // Marks a status read-back of channel 1 not yet followed by a read
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            rb_fresh_ff <= 1'b0;
        end else if (prog[1] || chan_rd[1]) begin
            rb_fresh_ff <= 1'b0;
        end else if (is_rb && !cmd.acc[0] && picks[1]) begin
            rb_fresh_ff <= 1'b1;
        end
    end

    sequence s_first_read1;
        chan_rd[1] && rb_fresh_ff;
    endsequence

    sequence s_refresh_seen;
        refresh_tick;
    endsequence

    AST_CFG_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
        cmd_wr && (cmd.acc == ACC_LATCH || cmd.sel == SEL_READBACK)
        |=> $stable(chan_cfg))
        else $error("Config changed on non-mode write");

    AST_ONE_LATCH: assert property (@(posedge sys_clk) disable iff (!reset_n)
        is_latch |-> $onehot(latch_cnt) && latch_stat == 3'h0)
        else $error("Latch command hit several channels");

    AST_STATUS_FIRST: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_first_read1 |=> io_rdata_ff[5:4] == chan_cfg[1].acc
            && io_rdata_ff[0] == chan_cfg[1].bcd)
        else $error("Status not returned first");

    AST_RB_PICK: assert property (@(posedge sys_clk) disable iff (!reset_n)
        is_rb |-> latch_cnt == (cmd.acc[1] ? 3'h0 : picks))
        else $error("Read-back count latch select wrong");

    AST_PB_ZERO: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pb_rd |=> io_rdata_ff[PB_PARITY:PB_CHCHK] == 2'h0)
        else $error("Port B high bits not zero");

    AST_PB_TIMER_TWO_LEVEL: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pb_rd |=> io_rdata_ff[PB_TIMER_TWO_LEVEL] == $past(timer_out[2]))
        else $error("Port B bit 5 not channel 2 output");

    AST_REFRESH: assert property (@(posedge sys_clk) disable iff (!reset_n)
        s_refresh_seen |=> pb_byte[PB_REFRESH] != $past(pb_byte[PB_REFRESH]))
        else $error("Refresh bit did not toggle");

    AST_GATE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        pb_wr |=> timer_gate[2] == $past(io_wdata[PB_GATE]) && timer_gate[1:0] == FIXED_GATES)
        else $error("Gate not driven from port B");

    AST_SPEAKER: assert property (@(posedge sys_clk) disable iff (!reset_n)
        !$past(pb_wr) && !$past(pb_wr, 2) |->
        speaker_drive == ($past(timer_out[2]) && $past(pb_byte[PB_SPK])))
        else $error("Speaker not gated by enable");
endmodule : itc_top

/* hdl/itc_pkg.sv */
// Purpose: Shared constants and types for the interval timer command port
// Assumes: Byte-wide I/O accesses, one system clock
// Notes: Command byte layout is shared by mode, latch and read-back writes
// Functional notes
// - Mode codes 110/111 act as modes 2/3
// - Format bit: binary 0-FFFFh or decimal 0-9999
// - Mode/format taken only if select!=11, access!=00
// - Mode write resets counter logic, count, pin
// - Access 00 latches count of selected counter
// - Latch command captures exactly one channel
// - Select 11 read-back; values readable immediately after
// - Latched count follows programmed access mode
// - Status read first, then count low/high
// - Read-back bit 5 low latches counts
// - Read-back bit 4 low latches status
// - Read-back bits 3..1 pick counters 2..0
// - Port B bits 7 and 6 read zero
// - Port B bit 5 reads channel 2 output
// - Port B bit 4 toggles per refresh
// - Port B bits 3..2 plain storage only
// - Port B bit 0 drives channel 2 gate
// - Only channel 2 gate controllable; others high
package itc_pkg;
    localparam int NUM_CHAN = 3;
    localparam logic [15:0] ADDR_PICK_TIMER_ZERO = 16'h0040;
    localparam logic [15:0] ADDR_PICK_TIMER_TWO = 16'h0042;
    localparam logic [15:0] ADDR_CMD = 16'h0043;
    localparam logic [15:0] ADDR_PORTB = 16'h0061;
    localparam logic [1:0] SEL_READBACK = 2'h3;
    localparam logic [1:0] ACC_LATCH = 2'h0;
    localparam logic [1:0] ACC_LSB = 2'h1;
    localparam logic [1:0] ACC_MSB = 2'h2;
    localparam logic [1:0] ACC_BOTH = 2'h3;
    localparam logic [2:0] MODE_ALIAS2 = 3'h6;
    localparam logic [2:0] MODE_ALIAS3 = 3'h7;
    localparam logic [2:0] MODE_TWO = 3'h2;
    localparam logic [2:0] MODE_THREE = 3'h3;
    localparam int PB_PARITY = 7;
    localparam int PB_CHCHK = 6;
    localparam int PB_TIMER_TWO_LEVEL = 5;
    localparam int PB_REFRESH = 4;
    localparam int PB_RSV_HI = 3;
    localparam int PB_RSV_LO = 2;
    localparam int PB_SPK = 1;
    localparam int PB_GATE = 0;
    localparam logic [7:0] RDATA_RESET = 8'h00;
    localparam logic [3:0] PB_RESET = 4'h0;
    localparam logic [1:0] FIXED_GATES = 2'h3;

    // Command byte; for read-back acc = {count_n, status_n}, mode = picks 2..0
    typedef struct packed {
        logic [1:0] sel;
        logic [1:0] acc;
        logic [2:0] mode;
        logic bcd;
    } itc_cmd_t;

    typedef struct packed {
        logic [1:0] acc;
        logic [2:0] mode;
        logic bcd;
    } itc_cfg_t;

    typedef enum logic [1:0] {
        PH_LOW = 2'b01,
        PH_HIGH = 2'b10
    } itc_phase_t;
endpackage : itc_pkg

/* hdl/itc_chan.sv */
// Purpose: Per-channel mode storage and count/status latches
// Assumes: Strobes are one-cycle pulses from the command decoder
// Notes: rd_byte is combinational; the top registers it
`timescale 1ns/1ps
module itc_chan (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic prog,
    input wire itc_pkg::itc_cmd_t cmd,
    input wire logic latch_cnt,
    input wire logic latch_stat,
    input wire logic rd,
    input wire logic [15:0] live_count,
    input wire logic out_level,
    input wire logic null_count,
    output logic [7:0] rd_byte,
    output itc_pkg::itc_cfg_t cfg_ff,
    output logic reprogram_ff
);
    import itc_pkg::*;

    logic [2:0] raw_mode_ff;
    logic [15:0] cnt_snap_ff;
    logic cnt_held_ff;
    logic [7:0] stat_snap_ff;
    logic stat_held_ff;
    itc_phase_t phase_ff;
    logic [15:0] src;
    logic last_byte;
    logic [2:0] eff_mode;

    always_comb begin
        eff_mode = cmd.mode;
        if (cmd.mode == MODE_ALIAS2) begin
            eff_mode = MODE_TWO;
        end else if (cmd.mode == MODE_ALIAS3) begin
            eff_mode = MODE_THREE;
        end
    end

    // Mode, format and access; format goes to the counting core as is
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_ff <= '0;
            raw_mode_ff <= '0;
        end else if (prog) begin
            cfg_ff <= '{acc: cmd.acc, mode: eff_mode, bcd: cmd.bcd};
            raw_mode_ff <= cmd.mode;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            reprogram_ff <= 1'b0;
        end else begin
            reprogram_ff <= prog;
        end
    end

    always_comb begin
        src = cnt_held_ff ? cnt_snap_ff : live_count;
        last_byte = (cfg_ff.acc != ACC_BOTH) || (phase_ff == PH_HIGH);
        if (stat_held_ff) begin
            rd_byte = stat_snap_ff;
        end else if (cfg_ff.acc == ACC_MSB || (cfg_ff.acc == ACC_BOTH && phase_ff == PH_HIGH)) begin
            rd_byte = src[15:8];
        end else begin
            rd_byte = src[7:0];
        end
    end

    // Further latches are ignored until the held value is read out
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_held_ff <= 1'b0;
            cnt_snap_ff <= '0;
        end else if (prog) begin
            cnt_held_ff <= 1'b0;
        end else if (latch_cnt && !cnt_held_ff) begin
            cnt_held_ff <= 1'b1;
            cnt_snap_ff <= live_count;
        end else if (rd && !stat_held_ff && last_byte) begin
            cnt_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stat_held_ff <= 1'b0;
            stat_snap_ff <= '0;
        end else if (prog) begin
            stat_held_ff <= 1'b0;
        end else if (latch_stat && !stat_held_ff) begin
            stat_held_ff <= 1'b1;
            stat_snap_ff <= {out_level, null_count, cfg_ff.acc, raw_mode_ff, cfg_ff.bcd};
        end else if (rd) begin
            stat_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_ff <= PH_LOW;
        end else if (prog) begin
            phase_ff <= PH_LOW;
        end else if (rd && !stat_held_ff && cfg_ff.acc == ACC_BOTH) begin
            phase_ff <= (phase_ff == PH_LOW) ? PH_HIGH : PH_LOW;
        end
    end

    AST_ALIAS_MODE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        prog && cmd.mode == MODE_ALIAS3 |=> cfg_ff.mode == MODE_THREE)
        else $error("Alias mode not mapped");

    AST_REPROG: assert property (@(posedge sys_clk) disable iff (!reset_n)
        prog |=> reprogram_ff && !cnt_held_ff && !stat_held_ff && phase_ff == PH_LOW
        ##1 reprogram_ff == $past(prog))
        else $error("Reprogram pulse wrong");

    AST_BOTH_ORDER: assert property (@(posedge sys_clk) disable iff (!reset_n)
        rd && !stat_held_ff && cnt_held_ff && cfg_ff.acc == ACC_BOTH && phase_ff == PH_LOW
        |-> rd_byte == cnt_snap_ff[7:0])
        else $error("Low byte not first");
endmodule : itc_chan

/* hdl/itc_portb.sv */
// Purpose: System control port storage, refresh toggle and speaker gating
// Assumes: refresh_tick is a one-cycle pulse per refresh
// Notes: Bits 7..4 are read-only status
`timescale 1ns/1ps
module itc_portb (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic wr,
    input wire logic [7:0] wdata,
    input wire logic t2_out,
    input wire logic refresh_tick,
    output logic [7:0] rd_byte,
    output logic gate_ff,
    output logic speaker_ff
);
    import itc_pkg::*;

    logic [3:0] bits_ff;
    logic toggle_ff;

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            bits_ff <= PB_RESET;
        end else if (wr) begin
            bits_ff <= wdata[PB_RSV_HI:PB_GATE];
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            toggle_ff <= 1'b0;
        end else if (refresh_tick) begin
            toggle_ff <= !toggle_ff;
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            gate_ff <= 1'b0;
            speaker_ff <= 1'b0;
        end else begin
            gate_ff <= wr ? wdata[PB_GATE] : bits_ff[PB_GATE];
            speaker_ff <= t2_out & bits_ff[PB_SPK];
        end
    end

    always_comb begin
        rd_byte = {2'h0, t2_out, toggle_ff, bits_ff};
    end
endmodule : itc_portb

/* test/itc_core_model.sv */
// Purpose: Behavioural counting cores that sit beside the command port
// Assumes: Bench loads counts through load/preset; OUT and null levels come from bench
// Notes: Refresh tick fires once every 16 clocks
`timescale 1ns/1ps
module itc_core_model (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [2:0] load,
    input wire logic [15:0] preset,
    input wire logic [2:0] chan_reprogram,
    output logic [2:0][15:0] count_live,
    output logic refresh_tick
);
    logic [3:0] div_ff;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_live <= '0;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (load[i]) begin
                    count_live[i] <= preset;
                end else if (chan_reprogram[i]) begin
                    count_live[i] <= 16'h0000;
                end
            end
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            div_ff <= 4'h0;
        end else begin
            div_ff <= div_ff + 4'h1;
        end
    end
    assign refresh_tick = (div_ff == 4'hf);
endmodule : itc_core_model

/* test/tb.sv */
// Purpose: Self-checking bench for the timer command port and port B
// Assumes: Inputs driven at the falling edge; read data checked a cycle later
// Notes: Refresh parity tracked by counting model ticks
`timescale 1ns/1ps
module tb;
    import itc_pkg::*;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [15:0] io_addr = 16'h0000;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata_ff;
    logic [2:0][15:0] count_live;
    logic [2:0] timer_out = 3'h0;
    logic [2:0] null_count = 3'h0;
    logic refresh_tick;
    itc_cfg_t [2:0] chan_cfg;
    logic [2:0] chan_reprogram;
    logic [2:0] timer_gate;
    logic speaker_drive;
    logic [2:0] load = 3'h0;
    logic [15:0] preset = 16'h0000;
    logic [2:0] em;
    int tick_cnt = 0;
    int errors = 0;
    int total_checks = 0;

    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (refresh_tick) begin
            tick_cnt <= tick_cnt + 1;
        end
    end

    itc_top DUT (.sys_clk(sys_clk), .reset_n(reset_n), .io_wr(io_wr), .io_rd(io_rd),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_rdata_ff(io_rdata_ff),
        .count_live(count_live), .timer_out(timer_out), .null_count(null_count),
        .refresh_tick(refresh_tick), .chan_cfg(chan_cfg), .chan_reprogram(chan_reprogram),
        .timer_gate(timer_gate), .speaker_drive(speaker_drive));
    itc_core_model u_core (.sys_clk(sys_clk), .reset_n(reset_n), .load(load),
        .preset(preset), .chan_reprogram(chan_reprogram), .count_live(count_live),
        .refresh_tick(refresh_tick));

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        io_wr = 1'b1;
        io_addr = a;
        io_wdata = d;
        @(negedge sys_clk);
        io_wr = 1'b0;
    endtask : wr

    // Port B expectation built at the read edge from live OUT and tick parity
    task automatic rd(input logic [15:0] a, input logic [7:0] exp, input string what);
        logic [7:0] e;
        @(negedge sys_clk);
        io_rd = 1'b1;
        io_addr = a;
        e = exp;
        if (a == ADDR_PORTB) begin
            e = {2'b00, timer_out[2], tick_cnt[0], exp[3:0]};
        end
        @(negedge sys_clk);
        io_rd = 1'b0;
        check(16'(io_rdata_ff), 16'(e), what);
    endtask : rd

    task automatic set_count(input int ch, input logic [15:0] v);
        @(negedge sys_clk);
        load = 3'b001 << ch;
        preset = v;
        @(negedge sys_clk);
        load = 3'h0;
    endtask : set_count

    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        close_out();
    end

    initial begin
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        reset_n = 1'b1;
        check(16'(timer_gate), 16'h0003, "fixed gates");
        check(16'(chan_cfg), 16'h0000, "cfg reset");
        check(16'(speaker_drive), 16'h0000, "speaker reset");
        check(16'(io_rdata_ff), 16'h0000, "rdata reset");
        $display("test reset done");
        for (int m = 0; m < 8; m++) begin
            em = (m > 5) ? 3'(m - 4) : 3'(m);
            wr(ADDR_CMD, {2'b01, 2'b11, 3'(m), 1'(m)});
            check(16'(chan_reprogram), 16'h0002, "reprogram pulse");
            check(16'(chan_cfg[1]), 16'({2'b11, em, 1'(m)}), "mode cfg");
        end
        wr(ADDR_CMD, 8'h40);
        check(16'(chan_cfg[1]), 16'h0037, "latch keeps cfg");
        check(16'(chan_reprogram), 16'h0000, "no reprogram");
        rd(16'h0041, 8'h00, "cleared low");
        rd(16'h0041, 8'h00, "cleared high");
        $display("test modes done");
        wr(ADDR_CMD, 8'h34);
        wr(ADDR_CMD, 8'h96);
        set_count(0, 16'h1234);
        set_count(2, 16'h5678);
        wr(ADDR_CMD, 8'h00);
        set_count(0, 16'habcd);
        rd(16'h0040, 8'h34, "latched low");
        rd(16'h0040, 8'h12, "latched high");
        rd(16'h0040, 8'hcd, "live after latch");
        rd(16'h0040, 8'hab, "live high after latch");
        rd(16'h0042, 8'h78, "other channel live");
        wr(ADDR_CMD, 8'h80);
        set_count(2, 16'h9abc);
        rd(16'h0042, 8'h78, "lsb only latched");
        rd(16'h0042, 8'hbc, "lsb only live");
        wr(ADDR_CMD, 8'ha6);
        set_count(2, 16'h1357);
        wr(ADDR_CMD, 8'h80);
        set_count(2, 16'h2468);
        rd(16'h0042, 8'h13, "msb only latched");
        $display("test latch done");
        timer_out = 3'b010;
        set_count(1, 16'hbeef);
        wr(ADDR_CMD, 8'hc4);
        set_count(1, 16'h0000);
        rd(16'h0041, 8'hbf, "status first");
        rd(16'h0041, 8'hef, "then low");
        rd(16'h0041, 8'hbe, "then high");
        set_count(0, 16'h0102);
        set_count(2, 16'h0304);
        wr(ADDR_CMD, 8'hda);
        set_count(0, 16'h0000);
        set_count(2, 16'h0000);
        rd(16'h0040, 8'h02, "rb ch0 low");
        rd(16'h0040, 8'h01, "rb ch0 high");
        rd(16'h0042, 8'h03, "rb ch2 msb");
        rd(16'h0041, 8'h00, "ch1 not picked");
        null_count = 3'b001;
        set_count(0, 16'h0a0b);
        wr(ADDR_CMD, 8'he2);
        set_count(0, 16'h0c0d);
        rd(16'h0040, 8'h74, "status only");
        rd(16'h0040, 8'h0d, "count not latched");
        $display("test readback done");
        timer_out = 3'b100;
        wr(ADDR_PORTB, 8'hff);
        check(16'(timer_gate), 16'h0007, "gate on");
        @(negedge sys_clk);
        check(16'(speaker_drive), 16'h0001, "speaker on");
        rd(ADDR_PORTB, 8'h0f, "port b all set");
        timer_out = 3'b000;
        @(negedge sys_clk);
        @(negedge sys_clk);
        check(16'(speaker_drive), 16'h0000, "speaker follows out");
        rd(ADDR_PORTB, 8'h0f, "out low seen");
        wr(ADDR_PORTB, 8'h08);
        check(16'(timer_gate), 16'h0003, "gate off");
        repeat (9) @(negedge sys_clk);
        rd(ADDR_PORTB, 8'h08, "storage kept");
        timer_out = 3'b100;
        repeat (3) @(negedge sys_clk);
        check(16'(speaker_drive), 16'h0000, "enable off silences");
        rd(ADDR_PORTB, 8'h08, "refresh toggled");
        rd(16'h0050, 8'h00, "unmapped read");
        $display("test port b done");
        close_out();
    end
endmodule : tb
